// File: xbe_pkg.sv
// Package for the exit, branch and address-transfer execution block.
// Assumes a 16-bit parcel instruction format with octal-style fields.
`default_nettype none
package xbe_pkg;
    localparam int ADDR_W = 24;
    localparam int SCAL_W = 64;
    localparam int SAVE_CNT = 64;
    localparam int IMM_W = 22;
    // Opcode values (7-bit g/h field)
    localparam logic [6:0] OP_NORMAL_EXIT = 7'h04;
    localparam logic [6:0] OP_BR_SAVE = 7'h05;
    localparam logic [6:0] OP_BR_IMM = 7'h06;
    localparam logic [6:0] OP_RETURN = 7'h07;
    localparam logic [6:0] OP_BRA_EQ = 7'h08;
    localparam logic [6:0] OP_BRA_NE = 7'h09;
    localparam logic [6:0] OP_BRA_POS = 7'h0a;
    localparam logic [6:0] OP_BRA_NEG = 7'h0b;
    localparam logic [6:0] OP_BRS_EQ = 7'h0c;
    localparam logic [6:0] OP_BRS_NE = 7'h0d;
    localparam logic [6:0] OP_BRS_POS = 7'h0e;
    localparam logic [6:0] OP_BRS_NEG = 7'h0f;
    localparam logic [6:0] OP_LOAD_IMM = 7'h10;
    localparam logic [6:0] OP_LOAD_IMM_CPL = 7'h11;
    localparam logic [6:0] OP_LOAD_SHORT = 7'h12;
    localparam logic [6:0] OP_SCAL_TO_ADDR = 7'h13;
    localparam logic [6:0] OP_SAVE_TO_ADDR = 7'h14;
    localparam logic [6:0] OP_ADDR_TO_SAVE = 7'h15;
    localparam logic [6:0] OP_POPCOUNT = 7'h16;
    localparam logic [6:0] OP_LZ_COUNT = 7'h17;
    localparam logic [6:0] OP_MONITOR = 7'h01;
    localparam logic [2:0] MON_I_EXCH = 3'h3;
    // Field positions inside the first parcel
    localparam int F_OP_LSB = 9;
    localparam int F_I_LSB = 6;
    localparam int F_J_LSB = 3;
    localparam int F_K_LSB = 0;
    localparam logic [6:0] LZ_ALL_ZERO = 7'h40;
    localparam logic [ADDR_W-1:0] EXCH_ADDR_RESET = 24'h000000;
endpackage
`default_nettype wire

// File: xbe_count.sv
// Population and leading-zero counter for one scalar word.
// Pure combinational; the caller registers the result.
`default_nettype none
module xbe_count
    import xbe_pkg::*;
#(
    parameter int W = SCAL_W
) (
    input wire logic [W-1:0] word,
    output logic [6:0] ones,
    output logic [6:0] leadZeros
);
    // Elaboration guard: the 7-bit counts only cover a 64-bit word
    if (W != 64) begin : g_width_check
        $error("xbe_count supports 64-bit words only");
    end

    // One loop gives both counts; a found flag stops the zero run
    always_comb begin
        logic found;
        found = 1'b0;
        ones = 7'h00;
        leadZeros = 7'h00;
        for (int b = W - 1; b >= 0; b--) begin
            if (word[b]) begin
                ones = ones + 7'h01;
                found = 1'b1;
            end else if (!found) begin
                leadZeros = leadZeros + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: xbe_exec.sv
// Execution block for exit, branch, immediate-load and address transfers.
// Assumes the issue stage presents one instruction per cycle with its
// second parcel already joined, and that register files read combinationally.
`default_nettype none
module xbe_exec
    import xbe_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic issueValid,
    input wire logic [15:0] parcel0,
    input wire logic [15:0] parcel1,
    input wire logic [AW-1:0] issueAddr,
    input wire logic supervisorMode,
    input wire logic pipeIdle,
    input wire logic [AW-1:0] addressRegisterZero,
    input wire logic [SCAL_W-1:0] scalarRegisterZero,
    input wire logic [AW-1:0] addrReadData,
    input wire logic [SCAL_W-1:0] scalReadData,
    input wire logic [AW-1:0] saveReadData,
    output logic issueReady,
    output logic twoParcel,
    output logic [2:0] addrReadSel,
    output logic [2:0] scalReadSel,
    output logic [5:0] saveReadSel,
    output logic addrWrEn,
    output logic [2:0] addrWrSel,
    output logic [AW-1:0] addrWrData,
    output logic saveWrEn,
    output logic [5:0] saveWrSel,
    output logic [AW-1:0] saveWrData,
    output logic pcLoad,
    output logic [AW-1:0] pcTarget,
    output logic exchangeJump,
    output logic [AW-1:0] exchangeAddr,
    output logic [AW-1:0] exchangeSavedPc,
    output logic bufferInvalidate,
    output logic normalExitFlagSet
);
    // Elaboration guard: the immediate packing assumes 24-bit addresses
    if (AW != 24) begin : g_width_check
        $error("xbe_exec needs 24-bit address registers");
    end

    typedef enum logic [0:0] {XBE_RUN, XBE_DRAIN} xbe_state_t;

    xbe_state_t state;
    logic [AW-1:0] exitPc;
    logic [6:0] opc;
    logic [2:0] fldI;
    logic [2:0] fldJ;
    logic [2:0] fldK;
    logic [5:0] shortField;
    logic [AW-1:0] longImm;
    logic [IMM_W-1:0] loadImm;
    logic [6:0] onesCnt;
    logic [6:0] lzCnt;
    logic take;
    logic branchHit;

    // Field extraction from the first parcel
    assign opc = parcel0[15:F_OP_LSB];
    assign fldI = parcel0[F_I_LSB+2:F_I_LSB];
    assign fldJ = parcel0[F_J_LSB+2:F_J_LSB];
    assign fldK = parcel0[F_K_LSB+2:F_K_LSB];
    assign shortField = {fldJ, fldK};
    // Low 24 bits of ijkm; the top bit of the 25-bit field is dropped
    assign longImm = {parcel0[7:0], parcel1};
    assign loadImm = {parcel0[5:0], parcel1};

    // Condition test: zero, nonzero, sign bit clear (zero included) or sign bit set
    function automatic logic test_hit(input logic [1:0] sel, input logic isZero,
                                      input logic signBit);
        case (sel)
            2'd0: test_hit = isZero;
            2'd1: test_hit = !isZero;
            2'd2: test_hit = !signBit;
            default: test_hit = signBit;
        endcase
    endfunction

    // Drain holds further issue until the exit has left
    assign issueReady = (state == XBE_RUN);
    assign take = issueValid && issueReady;

    // Read selects steer the register files
    assign addrReadSel = (opc == OP_MONITOR) ? fldJ : fldI;
    assign scalReadSel = fldJ;
    assign saveReadSel = shortField;

    // Two-parcel forms include every long-immediate branch
    always_comb begin
        twoParcel = 1'b0;
        case (opc)
            OP_BR_IMM, OP_RETURN, OP_BRA_EQ, OP_BRA_NE, OP_BRA_POS, OP_BRA_NEG,
            OP_BRS_EQ, OP_BRS_NE, OP_BRS_POS, OP_BRS_NEG,
            OP_LOAD_IMM, OP_LOAD_IMM_CPL: twoParcel = 1'b1;
            default: twoParcel = 1'b0;
        endcase
    end

    // Branch condition, zero counted positive on both files
    always_comb begin
        branchHit = 1'b0;
        if (opc[6:2] == OP_BRA_EQ[6:2]) begin
            branchHit = test_hit(opc[1:0], addressRegisterZero == '0,
                                 addressRegisterZero[AW-1]);
        end else if (opc[6:2] == OP_BRS_EQ[6:2]) begin
            branchHit = test_hit(opc[1:0], scalarRegisterZero == '0,
                                 scalarRegisterZero[SCAL_W-1]);
        end
    end

    xbe_count #(.W(SCAL_W)) u_count (
        .word(scalReadData),
        .ones(onesCnt),
        .leadZeros(lzCnt)
    );

    // Exit sequencing waits for earlier results before the jump
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= XBE_RUN;
            exitPc <= '0;
        end else begin
            case (state)
                XBE_RUN: begin
                    if (take && opc == OP_NORMAL_EXIT) begin
                        state <= XBE_DRAIN;
                        exitPc <= issueAddr + 24'h000001;
                    end
                end
                XBE_DRAIN: begin
                    if (pipeIdle) state <= XBE_RUN;
                end
                default: state <= XBE_RUN;
            endcase
        end
    end

    // Exchange jump and buffer void fire together once drained; the exit flag joins them outside supervisor mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exchangeJump <= 1'b0;
            bufferInvalidate <= 1'b0;
            normalExitFlagSet <= 1'b0;
            exchangeSavedPc <= '0;
        end else begin
            exchangeJump <= (state == XBE_DRAIN) && pipeIdle;
            bufferInvalidate <= (state == XBE_DRAIN) && pipeIdle;
            normalExitFlagSet <= (state == XBE_DRAIN) && pipeIdle
                                 && !supervisorMode;
            if (state == XBE_DRAIN && pipeIdle) exchangeSavedPc <= exitPc;
        end
    end

    // Exchange address register, loaded only by the supervisor form
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exchangeAddr <= EXCH_ADDR_RESET;
        end else if (take && opc == OP_MONITOR && fldI == MON_I_EXCH && supervisorMode) begin
            exchangeAddr <= (fldJ == 3'h0) ? '0 : addrReadData;
        end
    end

    // Program counter loads; a failed test leaves sequencing alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pcLoad <= 1'b0;
            pcTarget <= '0;
        end else begin
            pcLoad <= 1'b0;
            if (take) begin
                case (opc)
                    OP_BR_SAVE: begin
                        pcLoad <= 1'b1;
                        pcTarget <= saveReadData;
                    end
                    OP_BR_IMM, OP_RETURN: begin
                        pcLoad <= 1'b1;
                        pcTarget <= longImm;
                    end
                    default: begin
                        if (branchHit) begin
                            pcLoad <= 1'b1;
                            pcTarget <= longImm;
                        end
                    end
                endcase
            end
        end
    end
    // No load on a failed test: the issue stage simply advances
    // past both parcels.

    // Address register writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrWrEn <= 1'b0;
            addrWrSel <= 3'h0;
            addrWrData <= '0;
        end else begin
            addrWrEn <= 1'b0;
            addrWrSel <= fldI;
            if (take) begin
                case (opc)
                    OP_LOAD_IMM: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= {2'b00, loadImm};
                    end
                    OP_LOAD_IMM_CPL: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= ~{2'b00, loadImm};
                    end
                    OP_LOAD_SHORT: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= {18'h00000, shortField};
                    end
                    OP_SCAL_TO_ADDR: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= (fldJ == 3'h0) ? '0 : scalReadData[AW-1:0];
                    end
                    OP_SAVE_TO_ADDR: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= saveReadData;
                    end
                    OP_POPCOUNT: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= (fldJ == 3'h0) ? '0 : {17'h00000, onesCnt};
                    end
                    OP_LZ_COUNT: begin
                        addrWrEn <= 1'b1;
                        addrWrData <= {17'h00000,
                                       (fldJ == 3'h0) ? LZ_ALL_ZERO : lzCnt};
                    end
                    default: addrWrEn <= 1'b0;
                endcase
            end
        end
    end

    // Save register writes: return link and address-to-save transfer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            saveWrEn <= 1'b0;
            saveWrSel <= 6'h00;
            saveWrData <= '0;
        end else begin
            saveWrEn <= 1'b0;
            if (take && opc == OP_RETURN) begin
                saveWrEn <= 1'b1;
                saveWrSel <= 6'h00;
                saveWrData <= issueAddr + 24'h000002;
            end else if (take && opc == OP_ADDR_TO_SAVE) begin
                saveWrEn <= 1'b1;
                saveWrSel <= shortField;
                saveWrData <= addrReadData;
            end
        end
    end

    // Checks
    a_exit_drain_jump: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == XBE_DRAIN && pipeIdle) |=> exchangeJump && bufferInvalidate)
        else $error("exit did not jump");
    a_exit_flag_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        normalExitFlagSet |-> exchangeJump && !$past(supervisorMode))
        else $error("exit flag in supervisor mode");
    a_no_jump_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exchangeJump |-> $past(pipeIdle))
        else $error("jump before drain");
    a_saved_pc_plus: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_NORMAL_EXIT) ##1 pipeIdle |=>
        exchangeSavedPc == $past(issueAddr, 2) + 24'h000001)
        else $error("saved pc wrong");
    a_return_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_RETURN) |=> saveWrEn && saveWrSel == 6'h00
        && pcLoad && pcTarget == $past(longImm))
        else $error("return jump wrong");
    a_zero_positive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_BRA_NEG && addressRegisterZero == '0) |=> !pcLoad)
        else $error("zero taken as negative");
    a_scal_zero_pos: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_BRS_POS && scalarRegisterZero == '0) |=> pcLoad)
        else $error("scalar zero not positive");
    a_lz_zero_desig: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_LZ_COUNT && fldJ == 3'h0) |=>
        addrWrEn && addrWrData == 24'h000040)
        else $error("leading zero default wrong");
    a_imm_upper_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (take && opc == OP_LOAD_IMM) |=> addrWrData[AW-1:IMM_W] == 2'b00)
        else $error("immediate upper bits set");
endmodule
`default_nettype wire

// File: xbe_partner.sv
// Far-side model: issue-stage drain and the operating register files.
// Assumes the bench preloads the arrays and sets drainCycles before an exit.
`default_nettype none
module xbe_partner
    import xbe_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic issueValid,
    input wire logic issueReady,
    input wire logic [15:0] parcel0,
    input wire logic [7:0] drainCycles,
    input wire logic [2:0] addrReadSel,
    input wire logic [2:0] scalReadSel,
    input wire logic [5:0] saveReadSel,
    input wire logic addrWrEn,
    input wire logic [2:0] addrWrSel,
    input wire logic [ADDR_W-1:0] addrWrData,
    input wire logic saveWrEn,
    input wire logic [5:0] saveWrSel,
    input wire logic [ADDR_W-1:0] saveWrData,
    output logic pipeIdle,
    output logic [ADDR_W-1:0] addressRegisterZero,
    output logic [SCAL_W-1:0] scalarRegisterZero,
    output logic [ADDR_W-1:0] addrReadData,
    output logic [SCAL_W-1:0] scalReadData,
    output logic [ADDR_W-1:0] saveReadData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [ADDR_W-1:0] aReg [8];
    logic [SCAL_W-1:0] sReg [8];
    logic [ADDR_W-1:0] bReg [SAVE_CNT];
    logic [7:0] drainLeft;
    // Reads are combinational; a write is seen only after its edge
    assign addrReadData = aReg[addrReadSel];
    assign scalReadData = sReg[scalReadSel];
    assign saveReadData = bReg[saveReadSel];
    assign addressRegisterZero = aReg[0];
    assign scalarRegisterZero = sReg[0];
    assign pipeIdle = (drainLeft == 8'h00);
    // Earlier work stays in flight for drainCycles after an exit is taken
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drainLeft <= 8'h00;
        end else if (issueValid && issueReady && parcel0[15:9] == OP_NORMAL_EXIT) begin
            drainLeft <= drainCycles;
        end else if (!pipeIdle) begin
            drainLeft <= drainLeft - 8'h01;
        end
    end
    // Plain always: the bench preloads these arrays directly
    always @(posedge ref_clk) begin
        if (addrWrEn) aReg[addrWrSel] <= addrWrData;
        if (saveWrEn) bReg[saveWrSel] <= saveWrData;
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the exit, branch and address-transfer block.
// Assumes xbe_partner holds the register files and the pipeline drain.
`default_nettype none
module testbench
    import xbe_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic aw, bw, pc;
        logic [2:0] asel;
        logic [5:0] bsel;
        logic [ADDR_W-1:0] ad, bd, pt;
    } xbe_exp_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issueValid = 1'b0;
    logic supervisorMode = 1'b0;
    logic [15:0] parcel0 = 16'h0000;
    logic [15:0] parcel1 = 16'h0000;
    logic [ADDR_W-1:0] issueAddr = 24'h000000;
    logic [7:0] drainCycles = 8'h00;
    logic pipeIdle, issueReady, twoParcel, addrWrEn, saveWrEn, pcLoad, takeSeen, twoExp;
    logic exchangeJump, bufferInvalidate, normalExitFlagSet;
    logic [2:0] addrReadSel, scalReadSel, addrWrSel;
    logic [5:0] saveReadSel, saveWrSel;
    logic [ADDR_W-1:0] addressRegisterZero, addrReadData, saveReadData, addrWrData;
    logic [ADDR_W-1:0] saveWrData, pcTarget, exchangeAddr, exchangeSavedPc, exchAddrModel, lastAddr;
    logic [SCAL_W-1:0] scalarRegisterZero, scalReadData;
    logic [ADDR_W-1:0] mA [8];
    logic [SCAL_W-1:0] mS [8];
    logic [ADDR_W-1:0] mB [SAVE_CNT];
    logic [15:0] p;
    xbe_exp_t expQ [$];
    xbe_exp_t mon;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    always #4 ref_clk = ~ref_clk;

    xbe_exec dut_u (
        .ref_clk, .rst_n, .issueValid, .parcel0, .parcel1, .issueAddr, .supervisorMode,
        .pipeIdle, .addressRegisterZero, .scalarRegisterZero, .addrReadData, .scalReadData,
        .saveReadData, .issueReady, .twoParcel, .addrReadSel, .scalReadSel, .saveReadSel,
        .addrWrEn, .addrWrSel, .addrWrData, .saveWrEn, .saveWrSel, .saveWrData, .pcLoad,
        .pcTarget, .exchangeJump, .exchangeAddr, .exchangeSavedPc, .bufferInvalidate,
        .normalExitFlagSet
    );
    xbe_partner partner_u (
        .ref_clk, .rst_n, .issueValid, .issueReady, .parcel0, .drainCycles, .addrReadSel,
        .scalReadSel, .saveReadSel, .addrWrEn, .addrWrSel, .addrWrData, .saveWrEn,
        .saveWrSel, .saveWrData, .pipeIdle, .addressRegisterZero, .scalarRegisterZero,
        .addrReadData, .scalReadData, .saveReadData
    );

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Waits out pending writes first, else the partner would overwrite the preload
    task automatic preload(input logic zero);
        repeat (2) @(posedge ref_clk);
        for (int r = 0; r < 64; r++) begin
            if (r < 8) begin
                mA[r] = (zero && r == 0) ? 24'h0 : 24'($urandom);
                mS[r] = (zero && r == 0) ? 64'h0 : {$urandom, $urandom} >> ($urandom % 64);
                partner_u.aReg[r] = mA[r];
                partner_u.sReg[r] = mS[r];
            end
            mB[r] = 24'($urandom);
            partner_u.bReg[r] = mB[r];
        end
    endtask

    // Reference model of one instruction's port results
    task automatic predict(input logic [15:0] p0, input logic [15:0] p1, input logic sup,
            input logic [ADDR_W-1:0] addr);
        xbe_exp_t e;
        logic [6:0] op;
        logic [2:0] i;
        logic [2:0] j;
        logic [63:0] s;
        int n;
        e = '{default: '0};
        op = p0[15:9];
        i = p0[8:6];
        j = p0[5:3];
        s = (j == 3'h0) ? 64'h0 : mS[j];
        n = 0;
        while (n < 64 && !s[63 - n]) n++;
        e.asel = i;
        e.pt = (op == OP_BR_SAVE) ? mB[p0[5:0]] : {p0[7:0], p1};
        e.aw = op inside {[OP_LOAD_IMM:OP_SAVE_TO_ADDR], OP_POPCOUNT, OP_LZ_COUNT};
        case (op)
            OP_BR_SAVE, OP_BR_IMM: e.pc = 1'b1;
            OP_RETURN: begin
                e.pc = 1'b1;
                e.bw = 1'b1;
                e.bd = addr + 24'h2;
            end
            OP_BRA_EQ: e.pc = (mA[0] == 24'h0);
            OP_BRA_NE: e.pc = (mA[0] != 24'h0);
            OP_BRA_POS: e.pc = !mA[0][23];
            OP_BRA_NEG: e.pc = mA[0][23];
            OP_BRS_EQ: e.pc = (mS[0] == 64'h0);
            OP_BRS_NE: e.pc = (mS[0] != 64'h0);
            OP_BRS_POS: e.pc = !mS[0][63];
            OP_BRS_NEG: e.pc = mS[0][63];
            OP_LOAD_IMM: e.ad = {2'b00, p0[5:0], p1};
            OP_LOAD_IMM_CPL: e.ad = ~{2'b00, p0[5:0], p1};
            OP_LOAD_SHORT: e.ad = {18'h0, p0[5:0]};
            OP_SCAL_TO_ADDR: e.ad = s[23:0];
            OP_SAVE_TO_ADDR: e.ad = mB[p0[5:0]];
            OP_ADDR_TO_SAVE: begin
                e.bw = 1'b1;
                e.bsel = p0[5:0];
                e.bd = mA[i];
            end
            OP_POPCOUNT: e.ad = 24'($countones(s));
            OP_LZ_COUNT: e.ad = 24'(n);
            OP_MONITOR: if (sup && i == MON_I_EXCH) exchAddrModel = (j == 3'h0) ? 24'h0 : mA[j];
            default: ;
        endcase
        if (e.aw) mA[i] = e.ad;
        if (e.bw) mB[e.bsel] = e.bd;
        expQ.push_back(e);
    endtask

    // One instruction, then gap idle cycles; gap 0 keeps the next back to back
    task automatic drive(input logic [15:0] p0, input logic [15:0] p1, input logic sup,
            input int gap);
        lastAddr = 24'($urandom);
        @(posedge ref_clk);
        issueValid <= 1'b1;
        parcel0 <= p0;
        parcel1 <= p1;
        supervisorMode <= sup;
        issueAddr <= lastAddr;
        predict(p0, p1, sup, lastAddr);
        repeat (gap) begin
            @(posedge ref_clk);
            issueValid <= 1'b0;
        end
    endtask

    // Exit with a drain of d cycles; pulses land d + 2 falling edges after the take
    task automatic run_exit(input logic sup, input logic [7:0] d);
        drainCycles <= d;
        drive({OP_NORMAL_EXIT, 9'h027}, 16'h0000, sup, 1);
        for (int k = 1; k <= d + 2; k++) begin
            @(negedge ref_clk);
            check(exchangeJump === (k == d + 2), "jump timing");
            check(issueReady === (k == d + 2), "issue stall");
        end
        check(bufferInvalidate === 1'b1, "invalidate");
        check(normalExitFlagSet === !sup, "exit flag");
        check(exchangeAddr === exchAddrModel, "exchange address");
        check(exchangeSavedPc === lastAddr + 24'h1, "saved address");
    endtask

    assign twoExp = parcel0[15:9] inside {[OP_BR_IMM:OP_LOAD_IMM_CPL]};
    always @(posedge ref_clk) takeSeen <= rst_n && issueValid && issueReady;
    // Every result pulse is compared one cycle after its take
    always @(negedge ref_clk) begin
        if (issueValid) check(twoParcel === twoExp, "parcel count");
        if (takeSeen && expQ.size() > 0) begin
            mon = expQ.pop_front();
            check({addrWrEn, saveWrEn, pcLoad} === {mon.aw, mon.bw, mon.pc}, "pulses");
            if (mon.aw) check({addrWrSel, addrWrData} === {mon.asel, mon.ad}, "a");
            if (mon.bw) check({saveWrSel, saveWrData} === {mon.bsel, mon.bd}, "b");
            if (mon.pc) check(pcTarget === mon.pt, "target");
        end else if (rst_n) begin
            check({addrWrEn, saveWrEn, pcLoad} === 3'b000, "stray pulse");
        end
    end

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            $display("Error at %0t: run did not finish", $time);
            summarize();
        end
    end

    initial begin
        void'($urandom(32'had16fbe1));
        preload(1'b1);
        exchAddrModel = EXCH_ADDR_RESET;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check(issueReady === 1'b1 && exchangeAddr === EXCH_ADDR_RESET, "reset");
        $display("Test reset done");
        for (int r = 0; r < 2; r++) begin
            if (r == 1) preload(1'b0);
            for (int n = 0; n < 300; n++) begin
                p = 16'($urandom);
                p[15:9] = 7'($urandom % 23) + 7'h01;
                if (p[15:9] == OP_NORMAL_EXIT) p[15:9] = OP_MONITOR;
                drive(p, 16'($urandom), 1'($urandom), 1);
            end
            // Exchange address load, then a user-mode attempt that must be ignored
            drive({OP_MONITOR, MON_I_EXCH, 3'(r + 1), 3'h0}, 16'h0000, 1'b1, 1);
            drive({OP_MONITOR, MON_I_EXCH, 6'h28}, 16'h0000, 1'b0, 1);
            // Zero in address register zero is the awkward sign case
            drive({OP_LOAD_SHORT, 9'h000}, 16'h0000, 1'b0, 1);
            for (int n = 0; n < 24; n++) begin
                p = {OP_BRA_EQ + 7'(n % 8), 9'($urandom)};
                drive(p, 16'($urandom), 1'b0, (n == 23) ? 1 : 0);
            end
            run_exit(r[0], 8'h00);
            run_exit(!r[0], 8'h03);
            $display("Test round %0d done", r);
        end
        summarize();
    end
endmodule
`default_nettype wire
